/* File: shared/lamp_menu_pkg.sv */
// Shared constants, register map and types for the status lamp and menu controller.
package lamp_menu_pkg;

   // ---------------------------------------------------------------
   // Register map (byte addresses, one 32-bit word each)
   // ---------------------------------------------------------------
   localparam logic [7:0] reg_ctrl_a = 8'h00;
   localparam logic [7:0] reg_status_a = 8'h04;
   localparam logic [7:0] reg_irq_stat_a = 8'h08;
   localparam logic [7:0] reg_irq_mask_a = 8'h0C;
   localparam logic [7:0] reg_view_a = 8'h10;
   localparam logic [7:0] reg_value_a = 8'h14;

   // Control register fields.
   localparam int ctrl_init_done_b = 0;
   localparam int ctrl_master_init_b = 1;
   localparam int ctrl_comm_fault_b = 2;
   localparam int ctrl_tx_stall_b = 3;
   localparam int ctrl_good_read_b = 4;
   localparam int ctrl_poll_b = 5;

   // Interrupt status fields.
   localparam int irq_good_read_b = 0;
   localparam int irq_button_b = 1;
   localparam int irq_poll_b = 2;
   localparam int irq_bits_c = 3;

   // ---------------------------------------------------------------
   // Timing at 200 MHz
   // ---------------------------------------------------------------
   localparam int clk_mhz_c = 200;
   localparam int flash_ms_c = 250;
   localparam int blink_ms_c = 100;
   // Kept short enough that the backlight cycle count still fits a 32-bit int.
   localparam int backlight_s_c = 10;
   localparam int flash_cyc_c = flash_ms_c * clk_mhz_c * 1000;
   localparam int blink_cyc_c = blink_ms_c * clk_mhz_c * 1000;
   localparam int backlight_cyc_c = backlight_s_c * clk_mhz_c * 1000000;

   localparam logic [31:0] zero_word_c = 32'h0000_0000;
   localparam logic [4:0] master_addr_c = 5'h00;

   // Views in display order.
   typedef enum logic [2:0]
   {
      view_result,
      view_quality,
      device_status_view,
      view_io,
      station_address_view,
      view_align,
      view_version
   } view_t;

   // Network lamp states.
   typedef enum logic [1:0]
   {
      net_off,
      net_on,
      net_flash,
      net_error
   } net_lamp_t;

   // Lamp colour codes.
   localparam logic [1:0] lamp_off_c = 2'h0;
   localparam logic [1:0] lamp_green_c = 2'h1;
   localparam logic [1:0] lamp_red_c = 2'h2;

endpackage

/* File: shared/press_if.sv */
// Button event carrier between the debouncer and the controller.
`timescale 1ns/100ps
`default_nettype none
interface press_if;
   logic enter_press;
   logic down_press;
   modport src (output enter_press, output down_press);
   modport dst (input enter_press, input down_press);
endinterface
`default_nettype wire

/* File: logic/button_sync.sv */
// Button synchroniser that turns two pin levels into one-cycle press pulses.
`timescale 1ns/100ps
`default_nettype none
module button_sync
   import lamp_menu_pkg::*;
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Button pins, high while pressed.
   input wire logic enter_btn_i,
   input wire logic down_btn_i,
   // Press events.
   press_if.src press
);

   typedef struct packed
   {
      logic [2:0] enter_sync;
      logic [2:0] down_sync;
      logic enter_state;
      logic down_state;
      logic enter_pulse;
      logic down_pulse;
   } sync_state_t;

   sync_state_t st_q;
   sync_state_t st_d;

   // A level only counts once the second and third stages agree.
   always_comb
   begin
      st_d = st_q;
      st_d.enter_sync = {st_q.enter_sync[1:0], enter_btn_i};
      st_d.down_sync = {st_q.down_sync[1:0], down_btn_i};
      st_d.enter_pulse = 1'b0;
      st_d.down_pulse = 1'b0;
      if (st_q.enter_sync[1] == st_q.enter_sync[2])
      begin
         st_d.enter_state = st_q.enter_sync[2];
         st_d.enter_pulse = st_q.enter_sync[2] & ~st_q.enter_state;
      end
      if (st_q.down_sync[1] == st_q.down_sync[2])
      begin
         st_d.down_state = st_q.down_sync[2];
         st_d.down_pulse = st_q.down_sync[2] & ~st_q.down_state;
      end
   end

   // State register, frozen while the clock enable is low.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         st_q <= '0;
      else if (ce_i)
         st_q <= st_d;
   end

   assign press.enter_press = st_q.enter_pulse & ce_i;
   assign press.down_press = st_q.down_pulse & ce_i;

endmodule
`default_nettype wire

/* File: logic/blink_timer.sv */
// Free-running square wave used to flash the power and network lamps.
`timescale 1ns/100ps
`default_nettype none
module blink_timer
   import lamp_menu_pkg::*;
#(
   parameter int half_cyc = flash_cyc_c
)
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Flash phase.
   output logic phase_o
);

   typedef struct packed
   {
      logic [31:0] cnt;
      logic phase;
   } blink_state_t;

   blink_state_t st_q;
   blink_state_t st_d;

   // Toggle the phase every half period.
   always_comb
   begin
      st_d = st_q;
      if (st_q.cnt >= 32'(half_cyc - 1))
      begin
         st_d.cnt = zero_word_c;
         st_d.phase = ~st_q.phase;
      end
      else
         st_d.cnt = st_q.cnt + 32'h0000_0001;
   end

   // State register.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         st_q <= '0;
      else if (ce_i)
         st_q <= st_d;
   end

   assign phase_o = st_q.phase;

endmodule
`default_nettype wire

/* File: logic/lamp_menu_ctrl.sv */
// Status lamps, view menu, backlight and slave address logic of a networked reader.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Power-up always shows reading result view.
// - Enter toggles selection mode; display flashes.
// - Down steps to next view while selecting.
// - Views follow the fixed documented order.
// - Upper line names view; lower shows value.
// - Any press lights backlight; auto off later.
// - Power lamp flashes green during initialisation.
// - Power lamp steady green once ready.
// - Good read blinks power lamp off briefly.
// - Comm fault after master init flashes red.
// - Undeliverable data shows network error lamp.
// - Lamps behave the same with or without display.
// - Nonzero address selects polled slave operation.
// - Slave sends only when master polls; 31 max.
// - I/O view shows 0 inactive, 1 active.
module lamp_menu_ctrl
   import lamp_menu_pkg::*;
#(
   parameter int backlight_cyc = backlight_cyc_c,
   parameter int blink_cyc = blink_cyc_c,
   parameter int flash_cyc = flash_cyc_c,
   parameter int io_lines = 2
)
(
   // Clock, reset and enable.
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Wishbone slave.
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Pins from the operator panel and address switch.
   input wire logic enter_btn_i,
   input wire logic down_btn_i,
   input wire logic [4:0] addr_switch_i,
   input wire logic [io_lines-1:0] io_state_i,
   // Lamps, display and network side.
   output logic [1:0] power_status_lamp_o,
   output logic [1:0] net_lamp_o,
   output logic [2:0] view_title_o,
   output logic [31:0] view_value_o,
   output logic display_flash_o,
   output logic backlight_o,
   output logic slave_mode_o,
   output logic [4:0] station_addr_o,
   output logic tx_enable_o,
   output logic irq_o
);

   press_if press ();
   logic flash_phase;

   button_sync u_btn
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .enter_btn_i(enter_btn_i),
      .down_btn_i(down_btn_i),
      .press(press)
   );

   blink_timer #(.half_cyc(flash_cyc)) u_flash
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .phase_o(flash_phase)
   );

   // Next view in the fixed display order, wrapping after the version view.
   function automatic view_t next_view(input view_t v);
      if (v == view_version)
         next_view = view_result;
      else
         next_view = view_t'(v + 3'h1);
   endfunction

   // Lower-line value for a view; I/O lines sit one bit per line.
   function automatic logic [31:0] view_value(input view_t v, input logic [31:0] res,
      input logic [31:0] qual, input logic [31:0] err, input logic [31:0] io,
      input logic [4:0] adr, input logic [31:0] ver);
      case (v)
         view_result: view_value = res;
         view_quality: view_value = qual;
         device_status_view: view_value = err;
         view_io: view_value = io;
         station_address_view: view_value = {27'h000_0000, adr};
         view_align: view_value = qual;
         view_version: view_value = ver;
         default: view_value = zero_word_c;
      endcase
   endfunction

   typedef struct packed
   {
      logic [4:0][2:0] adr_sync;
      logic [4:0] adr;
      logic [io_lines-1:0][2:0] io_sync;
      logic [io_lines-1:0] io;
      logic [5:0] ctrl;
      logic [31:0] result;
      logic [31:0] quality;
      logic [31:0] error;
      logic [31:0] version;
      logic [irq_bits_c-1:0] irq_stat;
      logic [irq_bits_c-1:0] irq_mask;
      view_t view;
      logic selecting;
      logic [31:0] bl_cnt;
      logic backlight;
      logic [31:0] blink_cnt;
      logic [1:0] pwr_lamp;
      logic [1:0] net_lamp;
      logic [31:0] value;
      logic tx_en;
      logic slave;
      logic [31:0] rdata;
      logic ack;
      logic irq;
   } ctrl_state_t;

   ctrl_state_t st_q;
   ctrl_state_t st_d;

   logic wb_req;
   logic wb_wr;
   logic good_read_ev;
   logic poll_ev;
   logic any_press;
   logic [31:0] io_word;
   logic [31:0] wmask;
   net_lamp_t net_mode;

   assign wb_req = cyc_i & stb_i & ~st_q.ack;
   assign wb_wr = wb_req & we_i;
   assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
   assign good_read_ev = wb_wr && adr_i == reg_ctrl_a && dat_i[ctrl_good_read_b] && sel_i[0];
   assign poll_ev = wb_wr && adr_i == reg_ctrl_a && dat_i[ctrl_poll_b] && sel_i[0];
   assign any_press = press.enter_press | press.down_press;
   assign io_word = 32'(st_q.io);

   // Network lamp mode from the software status bits.
   always_comb
   begin
      if (st_q.ctrl[ctrl_tx_stall_b])
         net_mode = net_error;
      else if (st_q.ctrl[ctrl_master_init_b] && st_q.ctrl[ctrl_comm_fault_b])
         net_mode = net_flash;
      else if (st_q.ctrl[ctrl_master_init_b])
         net_mode = net_on;
      else
         net_mode = net_off;
   end

   // Whole controller: pins, bus, menu, backlight and lamps.
   always_comb
   begin
      st_d = st_q;
      // Three-stage pin synchronisers; stages two and three must agree.
      for (int i = 0; i < 5; i++)
      begin
         st_d.adr_sync[i] = {st_q.adr_sync[i][1:0], addr_switch_i[i]};
         if (st_q.adr_sync[i][1] == st_q.adr_sync[i][2])
            st_d.adr[i] = st_q.adr_sync[i][2];
      end
      for (int i = 0; i < io_lines; i++)
      begin
         st_d.io_sync[i] = {st_q.io_sync[i][1:0], io_state_i[i]};
         if (st_q.io_sync[i][1] == st_q.io_sync[i][2])
            st_d.io[i] = st_q.io_sync[i][2];
      end

      // Bus slave: one wait state, ack for one cycle.
      st_d.ack = wb_req;
      st_d.rdata = zero_word_c;
      if (wb_req && !we_i)
      begin
         case (adr_i)
            reg_ctrl_a: st_d.rdata = 32'(st_q.ctrl[3:0]);
            reg_status_a: st_d.rdata = {20'h0_0000, st_q.adr, st_q.selecting,
               st_q.view, st_q.backlight, st_q.tx_en, (st_q.adr != master_addr_c)};
            reg_irq_stat_a: st_d.rdata = 32'(st_q.irq_stat);
            reg_irq_mask_a: st_d.rdata = 32'(st_q.irq_mask);
            reg_view_a: st_d.rdata = 32'(st_q.view);
            reg_value_a: st_d.rdata = st_q.value;
            default: st_d.rdata = zero_word_c;
         endcase
      end
      if (wb_wr)
      begin
         case (adr_i)
            reg_ctrl_a: if (sel_i[0]) st_d.ctrl = {2'h0, dat_i[3:0]};
            reg_irq_stat_a: if (sel_i[0])
               st_d.irq_stat = st_q.irq_stat & ~dat_i[irq_bits_c-1:0];
            reg_irq_mask_a: if (sel_i[0]) st_d.irq_mask = dat_i[irq_bits_c-1:0];
            reg_view_a: st_d.result = (st_q.result & ~wmask) | (dat_i & wmask);
            reg_value_a: st_d.quality = (st_q.quality & ~wmask) | (dat_i & wmask);
            default: st_d.error = st_q.error;
         endcase
      end

      // Menu: enter toggles selection, down steps only while selecting.
      if (press.enter_press)
         st_d.selecting = ~st_q.selecting;
      if (press.down_press && st_q.selecting)
         st_d.view = next_view(st_q.view);

      // Backlight restarts its countdown on every press.
      if (any_press)
      begin
         st_d.backlight = 1'b1;
         st_d.bl_cnt = 32'(backlight_cyc - 1);
      end
      else if (st_q.bl_cnt != zero_word_c)
         st_d.bl_cnt = st_q.bl_cnt - 32'h0000_0001;
      else
         st_d.backlight = 1'b0;

      // Good read starts the brief off-blink of the power lamp.
      if (good_read_ev && st_q.ctrl[ctrl_init_done_b])
         st_d.blink_cnt = 32'(blink_cyc);
      else if (st_q.blink_cnt != zero_word_c)
         st_d.blink_cnt = st_q.blink_cnt - 32'h0000_0001;

      // Power lamp ignores whether a display is fitted.
      if (!st_q.ctrl[ctrl_init_done_b])
         st_d.pwr_lamp = flash_phase ? lamp_green_c : lamp_off_c;
      else if (st_q.blink_cnt != zero_word_c)
         st_d.pwr_lamp = lamp_off_c;
      else
         st_d.pwr_lamp = lamp_green_c;

      case (net_mode)
         net_error: st_d.net_lamp = lamp_red_c;
         net_flash: st_d.net_lamp = flash_phase ? lamp_red_c : lamp_off_c;
         net_on: st_d.net_lamp = lamp_green_c;
         default: st_d.net_lamp = lamp_off_c;
      endcase

      // Transmit only on a master poll and only as a valid slave.
      st_d.tx_en = poll_ev && (st_q.adr != master_addr_c);
      // Registered so the slave flag leaves the block straight from a flip-flop.
      st_d.slave = st_q.adr != master_addr_c;

      st_d.value = view_value(st_q.view, st_q.result, st_q.quality, st_q.error, io_word,
         st_q.adr, st_q.version);

      // Sticky events; a new event wins over a same-cycle clear.
      if (good_read_ev)
         st_d.irq_stat[irq_good_read_b] = 1'b1;
      if (any_press)
         st_d.irq_stat[irq_button_b] = 1'b1;
      if (poll_ev)
         st_d.irq_stat[irq_poll_b] = 1'b1;
      st_d.irq = |(st_d.irq_stat & st_q.irq_mask);
   end

   // State register; reset forces the reading result view.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_q <= '0;
         st_q.view <= view_result;
      end
      else if (ce_i)
         st_q <= st_d;
   end

   assign dat_o = st_q.rdata;
   assign ack_o = st_q.ack;
   assign power_status_lamp_o = st_q.pwr_lamp;
   assign net_lamp_o = st_q.net_lamp;
   assign view_title_o = st_q.view;
   assign view_value_o = st_q.value;
   assign display_flash_o = st_q.selecting;
   assign backlight_o = st_q.backlight;
   assign slave_mode_o = st_q.slave;
   assign station_addr_o = st_q.adr;
   assign tx_enable_o = st_q.tx_en;
   assign irq_o = st_q.irq;

   // Checks of the lamp, menu, backlight and transmit timing.
   a_reset_view: assert property (@(posedge clk_i)
      $fell(rst_i) |-> view_title_o == view_result)
      else $error("view not reading result after reset");
   a_enter_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && press.enter_press |=> display_flash_o != $past(display_flash_o))
      else $error("enter did not toggle selection");
   a_down_step: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && press.down_press && st_q.selecting
      |=> view_title_o == next_view($past(st_q.view)))
      else $error("down did not advance view");
   a_down_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && press.down_press && !st_q.selecting |=> $stable(view_title_o))
      else $error("view moved outside selection mode");
   a_wrap_view: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && press.down_press && st_q.selecting && st_q.view == view_version
      |=> view_title_o == view_result)
      else $error("view did not wrap");
   a_backlight_on: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && (press.enter_press || press.down_press) |=> backlight_o)
      else $error("backlight not lit by press");
   // During initialisation the lamp must follow the flash phase, not merely avoid red.
   a_init_green: assert property (@(posedge clk_i) disable iff (rst_i)
      !st_q.ctrl[ctrl_init_done_b] && ce_i
      |=> power_status_lamp_o == ($past(flash_phase) ? lamp_green_c : lamp_off_c))
      else $error("power lamp wrong during init");
   // The good read write must also keep the device ready, or the lamp flashes instead.
   sequence good_read_s;
      ce_i && good_read_ev && st_q.ctrl[ctrl_init_done_b] && dat_i[ctrl_init_done_b];
   endsequence
   a_read_blink: assert property (@(posedge clk_i) disable iff (rst_i)
      good_read_s ##1 ce_i |=> power_status_lamp_o == lamp_off_c)
      else $error("good read did not blink lamp");
   // Checked on the rising edge only, since a frozen enable may hold the pulse high.
   a_tx_slave: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(tx_enable_o) |-> $past(station_addr_o) != master_addr_c && $past(poll_ev))
      else $error("transmit without poll or address");
   a_net_error: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && st_q.ctrl[ctrl_tx_stall_b] |=> net_lamp_o == lamp_red_c)
      else $error("network error lamp missing");

endmodule
`default_nettype wire

/* File: dv/panel_model.sv */
// Operator panel model: pushbuttons, address switch and input/output lines.
`timescale 1ns/100ps
`default_nettype none
module panel_model
(
   // Clock.
   input wire logic clk_i,
   // Pins toward the controller.
   output logic enter_btn_o,
   output logic down_btn_o,
   output logic [4:0] addr_switch_o,
   output logic [1:0] io_state_o
);
   // Buttons rest released; the switch starts at the master's own address.
   initial
   begin
      enter_btn_o = 1'b0;
      down_btn_o = 1'b0;
      addr_switch_o = 5'h00;
      io_state_o = 2'h0;
   end

   // A press is held well past the three-stage synchroniser, then released long enough to settle.
   task automatic press(input bit down);
      @(posedge clk_i);
      if (down)
         down_btn_o <= 1'b1;
      else
         enter_btn_o <= 1'b1;
      repeat (6) @(posedge clk_i);
      down_btn_o <= 1'b0;
      enter_btn_o <= 1'b0;
      repeat (8) @(posedge clk_i);
      @(negedge clk_i);
   endtask

   // Switch and line levels change together; the wait covers the input synchronisers.
   task automatic set_pins(input logic [4:0] adr, input logic [1:0] io);
      @(posedge clk_i);
      addr_switch_o <= adr;
      io_state_o <= io;
      repeat (6) @(posedge clk_i);
      @(negedge clk_i);
   endtask
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking testbench for the status lamp and menu controller.
`timescale 1ns/100ps
`default_nettype none
module tb
   import lamp_menu_pkg::*;
;
   // -----------------------------------------------------------
   // Signals, clock and instances
   // -----------------------------------------------------------
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic [3:0] sel_i = 4'h0;
   logic [3:0] sel = 4'hF;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0000_0000;
   logic [31:0] dat_o;
   logic ack_o;
   logic enter_btn, down_btn, slave_mode_o, tx_enable_o, irq_o;
   logic display_flash_o, backlight_o;
   logic [4:0] addr_switch, station_addr_o;
   logic [1:0] io_state, power_status_lamp_o, net_lamp_o;
   logic [2:0] view_title_o;
   logic [31:0] view_value_o;
   logic [31:0] seed = 32'h0000_28C7;
   int error_cnt = 0;
   int checks = 0;
   int tx_cnt = 0;

   always #2.5 clk_i = ~clk_i;

   lamp_menu_ctrl #(.backlight_cyc(100), .blink_cyc(10), .flash_cyc(8), .io_lines(2))
   i_lamp_menu_ctrl (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .enter_btn_i(enter_btn), .down_btn_i(down_btn),
      .addr_switch_i(addr_switch), .io_state_i(io_state),
      .power_status_lamp_o(power_status_lamp_o), .net_lamp_o(net_lamp_o),
      .view_title_o(view_title_o), .view_value_o(view_value_o),
      .display_flash_o(display_flash_o), .backlight_o(backlight_o),
      .slave_mode_o(slave_mode_o), .station_addr_o(station_addr_o),
      .tx_enable_o(tx_enable_o), .irq_o(irq_o));

   panel_model i_panel_model (.clk_i(clk_i), .enter_btn_o(enter_btn), .down_btn_o(down_btn),
      .addr_switch_o(addr_switch), .io_state_o(io_state));

   // Transmit pulses are counted so a missing or extra one shows up.
   always @(posedge clk_i)
      if (tx_enable_o === 1'b1)
         tx_cnt++;

   // -----------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------
   function automatic logic [31:0] xorshift();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // The menu wraps after the version view.
   function automatic logic [2:0] next_view(input logic [2:0] v);
      return (v == 3'h6) ? 3'h0 : v + 3'h1;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Classic single cycle; the wait is bounded so a silent slave cannot hang the run.
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                     output logic [31:0] rd);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= we;
      sel_i <= sel;
      adr_i <= adr;
      dat_i <= wd;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack_o !== 1'b1 && n < 20);
      chk(32'(n < 20), 32'h0000_0001);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(negedge clk_i);
   endtask

   // Records which lamp codes appear over a span, catching flashing versus steady.
   task automatic watch(input bit net, input int n, output logic [3:0] seen);
      seen = 4'h0;
      repeat (n)
      begin
         @(negedge clk_i);
         seen[net ? net_lamp_o : power_status_lamp_o] = 1'b1;
      end
   endtask

   task automatic stop_test();
      if (error_cnt == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Watchdog sized well beyond the main sequence.
   initial
   begin
      #(30000 * 5);
      error_cnt++;
      stop_test();
   end

   // -----------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------
   initial
   begin
      logic [31:0] rd;
      logic [31:0] word;
      logic [4:0] adr;
      logic [1:0] io;
      logic [3:0] seen;
      logic [2:0] v;
      int t0;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      chk(32'(view_title_o), 32'h0000_0000);
      chk({30'h0, display_flash_o, backlight_o}, 32'h0000_0000);
      watch(1'b0, 40, seen);
      chk(32'(seen), 32'h0000_0003);
      // Address zero stays off the network, so a poll must not transmit.
      word = xorshift();
      io = word[1:0];
      i_panel_model.set_pins(5'h00, io);
      t0 = tx_cnt;
      wb(1'b1, reg_ctrl_a, 32'h0000_0020, rd);
      repeat (4) @(negedge clk_i);
      chk(32'(slave_mode_o), 32'h0000_0000);
      chk(32'(tx_cnt - t0), 32'h0000_0000);
      adr = 5'(word[15:8] % 31) + 5'h01;
      i_panel_model.set_pins(adr, io);
      t0 = tx_cnt;
      wb(1'b1, reg_ctrl_a, 32'h0000_0020, rd);
      repeat (4) @(negedge clk_i);
      chk(32'(tx_cnt - t0), 32'h0000_0001);
      wb(1'b0, reg_status_a, 32'h0000_0000, rd);
      chk({26'h0, rd[11:7], rd[0]}, {26'h0, adr, 1'b1});
      chk(32'(station_addr_o), 32'(adr));
      // Power and network lamps.
      wb(1'b1, reg_ctrl_a, 32'h0000_0001, rd);
      watch(1'b0, 20, seen);
      chk(32'(seen), 32'h0000_0002);
      wb(1'b1, reg_ctrl_a, 32'h0000_0011, rd);
      watch(1'b0, 6, seen);
      chk(32'(seen[0]), 32'h0000_0001);
      repeat (15) @(negedge clk_i);
      chk(32'(power_status_lamp_o), 32'(lamp_green_c));
      wb(1'b1, reg_ctrl_a, 32'h0000_0003, rd);
      repeat (2) @(negedge clk_i);
      chk(32'(net_lamp_o), 32'(lamp_green_c));
      wb(1'b1, reg_ctrl_a, 32'h0000_0007, rd);
      watch(1'b1, 40, seen);
      chk(32'(seen), 32'h0000_0005);
      wb(1'b1, reg_ctrl_a, 32'h0000_000F, rd);
      watch(1'b1, 20, seen);
      chk(32'(seen), 32'h0000_0004);
      // Menu walk through every view, wrapping at the end.
      word = xorshift();
      wb(1'b1, reg_view_a, word, rd);
      repeat (3) @(negedge clk_i);
      chk(view_value_o, word);
      i_panel_model.press(1'b0);
      chk({29'h0, display_flash_o, backlight_o, view_title_o == 3'h0}, 32'h0000_0007);
      v = 3'h0;
      repeat (8)
      begin
         i_panel_model.press(1'b1);
         v = next_view(v);
         chk(32'(view_title_o), 32'(v));
         if (v == 3'h3)
            chk(32'(view_value_o[1:0]), 32'(io));
         if (v == 3'h4)
            chk(32'(view_value_o[4:0]), 32'(adr));
      end
      i_panel_model.press(1'b0);
      chk({28'h0, display_flash_o, view_title_o}, 32'h0000_0001);
      // Only the two low byte lanes of the quality word take this write.
      word = xorshift();
      sel = 4'h3;
      wb(1'b1, reg_value_a, word, rd);
      sel = 4'hF;
      repeat (3) @(negedge clk_i);
      chk(view_value_o, word & 32'h0000_FFFF);
      // Down outside selection leaves the view unchanged but restarts the backlight.
      i_panel_model.press(1'b1);
      chk({28'h0, backlight_o, view_title_o}, 32'h0000_0009);
      // A frozen enable stretches the backlight; without it the next check would see it off.
      @(posedge clk_i);
      ce_i <= 1'b0;
      repeat (30) @(posedge clk_i);
      ce_i <= 1'b1;
      repeat (80) @(negedge clk_i);
      chk(32'(backlight_o), 32'h0000_0001);
      repeat (30) @(negedge clk_i);
      chk(32'(backlight_o), 32'h0000_0000);
      // Interrupt: raise, mask, clear; then an unmapped read.
      wb(1'b1, reg_irq_stat_a, 32'h0000_0007, rd);
      wb(1'b1, reg_ctrl_a, 32'h0000_0011, rd);
      wb(1'b0, reg_irq_stat_a, 32'h0000_0000, rd);
      chk({29'h0, rd[2:0]}, 32'h0000_0001);
      chk(32'(irq_o), 32'h0000_0000);
      wb(1'b1, reg_irq_mask_a, 32'h0000_0001, rd);
      repeat (2) @(negedge clk_i);
      chk(32'(irq_o), 32'h0000_0001);
      wb(1'b1, reg_irq_stat_a, 32'h0000_0001, rd);
      repeat (2) @(negedge clk_i);
      chk(32'(irq_o), 32'h0000_0000);
      wb(1'b0, 8'h20, 32'h0000_0000, rd);
      chk(rd, zero_word_c);
      // A second reset in mid-run must bring back the reading result view.
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      chk({29'h0, view_title_o}, 32'h0000_0000);
      stop_test();
   end
endmodule
`default_nettype wire
